// ==== rtl/radio_link_regs_pkg.sv ====
package radio_link_regs_pkg;

  // Register offsets, bank 0
  localparam logic [4:0] ADDR_WIDTH_SETUP_OFS    = 5'h03;
  localparam logic [4:0] RETRANSMIT_SETUP_OFS    = 5'h04;
  localparam logic [4:0] RADIO_CHANNEL_OFS       = 5'h05;
  localparam logic [4:0] RADIO_SETUP_OFS         = 5'h06;
  localparam logic [4:0] EVENT_STATUS_OFS        = 5'h07;
  localparam logic [4:0] TRANSMIT_OBSERVE_OFS    = 5'h08;
  localparam logic [4:0] CARRIER_PRESENT_OFS     = 5'h09;
  localparam logic [4:0] PIPE0_ADDR_OFS          = 5'h0A;
  localparam logic [4:0] PIPE1_ADDR_OFS          = 5'h0B;
  localparam logic [4:0] PIPE2_LOW_OFS           = 5'h0C;
  localparam logic [4:0] PIPE3_LOW_OFS           = 5'h0D;
  localparam logic [4:0] PIPE4_LOW_OFS           = 5'h0E;
  localparam logic [4:0] PIPE5_LOW_OFS           = 5'h0F;
  localparam logic [4:0] TRANSMIT_ADDR_OFS       = 5'h10;

  // Serial command encodings
  localparam logic [2:0] CMD_READ_PREFIX         = 3'h0;
  localparam logic [2:0] CMD_WRITE_PREFIX        = 3'h1;
  localparam logic [7:0] BANK_TOGGLE_COMMAND     = 8'h50;
  localparam logic [7:0] BANK_TOGGLE_KEY         = 8'h53;

  // Field positions
  localparam int STAT_BANK_BIT   = 7;
  localparam int STAT_RX_BIT     = 6;
  localparam int STAT_TX_BIT     = 5;
  localparam int STAT_RETRY_BIT  = 4;

  // Reset values
  localparam logic [1:0]  WIDTH_CODE_RST         = 2'h3;
  localparam logic [3:0]  RETRY_DELAY_RST        = 4'h0;
  localparam logic [3:0]  RETRY_LIMIT_RST        = 4'h3;
  localparam logic [6:0]  RADIO_CHANNEL_RST      = 7'h02;
  localparam logic [7:0]  RADIO_SETUP_RST        = 8'h3F;
  localparam logic [2:0]  PIPE_NUM_EMPTY         = 3'h7;
  localparam logic [39:0] PIPE0_ADDR_RST         = 40'hE7E7E7E7E7;
  localparam logic [39:0] PIPE1_ADDR_RST         = 40'hC2C2C2C2C2;
  localparam logic [7:0]  PIPE2_LOW_RST          = 8'hC3;
  localparam logic [7:0]  PIPE3_LOW_RST          = 8'hC4;
  localparam logic [7:0]  PIPE4_LOW_RST          = 8'hC5;
  localparam logic [7:0]  PIPE5_LOW_RST          = 8'hC6;
  localparam logic [39:0] TRANSMIT_ADDR_RST      = 40'hE7E7E7E7E7;

  // Retry delay timing: 250 us per step, code 0 is one step
  localparam int CLK_FREQ_MHZ       = 20;
  localparam int RETRY_STEP_US      = 250;
  localparam int RETRY_STEP_CYCLES  = RETRY_STEP_US * CLK_FREQ_MHZ;

endpackage

// ==== rtl/radio_link_config_status_regs.sv ====
`timescale 1ns/100ps
// How it works
// - Width code 01/10/11 gives 3/4/5 address bytes, 00 illegal, reset 11.
// - Below five bytes only the low address bytes are used.
// - Retry delay code sets wait between transmissions, 250 us per step.
// - Retry limit zero disables retries, else up to limit retries; reset 3.
// - Channel register holds seven-bit channel, reset 2, bit 7 reads zero.
// - Radio setup holds power level, air rate and receive gain fields.
// - Status byte shifts out while the host shifts in each command byte.
// - Status bit 7 shows bank; toggle command plus 0x53 flips it.
// - Receive-ready flag sets on new payload, clears on write of one.
// - Sent flag sets on transmit when auto-ack is off, on acknowledge when auto-ack is on.
// - Retry-exhausted flag clears on write one; blocks traffic while set.
// - Status bits 3:1 give pipe number, 111 when receive FIFO empty.
// - Status bit 0 reads one when the transmit FIFO is full.
// - Lost-packet count saturates at 15, cleared by channel register write.
// - Retry count counts retransmissions, zeroed when a new packet starts.
// - Pipe 0 and 1 addresses are 40 bits, written low byte first.
// - Pipes 2 to 5 store low byte; upper bytes come from pipe 1.
// - Unmasked set event flags drive the interrupt pin low.
// - Multi-byte values go low byte first, each byte high bit first.
module radio_link_config_status_regs #(
  parameter int RETRY_STEP_CYCLES = radio_link_regs_pkg::RETRY_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // Serial command port
  input  wire logic        i_sck,
  input  wire logic        i_csn,
  input  wire logic        i_mosi,
  output logic             o_miso,
  output logic             o_miso_oe,
  output logic             o_irq_n,
  // Event inputs from the radio engine
  input  wire logic        i_rx_payload_arrived,
  input  wire logic [2:0]  i_rx_pipe_num,
  input  wire logic        i_tx_done,
  input  wire logic        i_ack_received,
  input  wire logic        i_auto_ack_active,
  input  wire logic        i_ack_timeout,
  input  wire logic        i_new_packet_start,
  input  wire logic        i_tx_fifo_full,
  input  wire logic        i_carrier_present,
  // Interrupt masks held in the configuration register
  input  wire logic        i_rx_ready_irq_mask,
  input  wire logic        i_tx_sent_irq_mask,
  input  wire logic        i_retry_limit_irq_mask,
  // Settings to the radio engine
  output logic [1:0]       o_width_code,
  output logic [6:0]       o_radio_channel,
  output logic             o_air_rate_select,
  output logic [1:0]       o_output_power_level,
  output logic             o_rx_gain_high,
  output logic             o_bank_indicator,
  output logic             o_comm_blocked,
  output logic             o_retransmit_go,
  output logic [39:0]      o_pipe0_addr,
  output logic [39:0]      o_pipe1_addr,
  output logic [39:0]      o_pipe2_addr,
  output logic [39:0]      o_pipe3_addr,
  output logic [39:0]      o_pipe4_addr,
  output logic [39:0]      o_pipe5_addr,
  output logic [39:0]      o_tx_addr
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [1:0]  width_code_r;
  logic [3:0]  retry_delay_code_r;
  logic [3:0]  retry_limit_r;
  logic [6:0]  radio_channel_r;
  logic [7:0]  radio_setup_r;
  logic        bank_indicator_r;
  logic        rx_data_ready_flag_r;
  logic        tx_data_sent_flag_r;
  logic        retry_exhausted_flag_r;
  logic [2:0]  pipe_num_r;
  logic        tx_full_r;
  logic [3:0]  lost_packet_count_r;
  logic [3:0]  retry_count_r;
  logic        carrier_present_r;
  logic [39:0] pipe0_receive_address_r;
  logic [39:0] pipe1_receive_address_r;
  logic [7:0]  pipe_low_r [2:5];
  logic [39:0] transmit_address_r;

  // Serial engine state
  logic        sck_q_r;
  logic [2:0]  bit_cnt_r;
  logic [2:0]  byte_cnt_r;
  logic [6:0]  rx_sh_r;
  logic [7:0]  cmd_r;
  logic [7:0]  tx_sh_r;

  // Retry delay timer
  logic [16:0] delay_cnt_r;
  logic        delay_run_r;

  // Derived strobes
  logic        sck_rise;
  logic        sck_fall;
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic [7:0]  status_byte;
  logic [4:0]  cur_addr;
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [7:0]  wr_data;
  logic        exhaust;
  logic        retry_start;
  logic        tx_sent_evt;
  logic        rx_clr, tx_clr, rt_clr;
  logic        rx_nxt, tx_nxt, rt_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Keep only the low address bytes the width code selects
  function automatic logic [39:0] mask_addr(input logic [39:0] a, input logic [1:0] wc);
    case (wc)
      2'h1:    mask_addr = {16'h0000, a[23:0]};
      2'h2:    mask_addr = {8'h00, a[31:0]};
      default: mask_addr = a;                   // Illegal code treated as full width
    endcase
  endfunction

  // Byte idx of a 40-bit value, zero past the top
  function automatic logic [7:0] byte_of(input logic [39:0] v, input logic [2:0] idx);
    byte_of = (idx < 3'h5) ? v[idx*8 +: 8] : 8'h00;
  endfunction

  // Read data for register a, byte idx
  function automatic logic [7:0] read_byte(input logic [4:0] a, input logic [2:0] idx,
                                           input logic [7:0] st);
    logic [7:0] b0;
    b0 = 8'h00;
    case (a)
      radio_link_regs_pkg::ADDR_WIDTH_SETUP_OFS: b0 = {6'h00, width_code_r};
      radio_link_regs_pkg::RETRANSMIT_SETUP_OFS: b0 = {retry_delay_code_r, retry_limit_r};
      radio_link_regs_pkg::RADIO_CHANNEL_OFS:    b0 = {1'b0, radio_channel_r};
      radio_link_regs_pkg::RADIO_SETUP_OFS:      b0 = radio_setup_r;
      radio_link_regs_pkg::EVENT_STATUS_OFS:     b0 = st;
      radio_link_regs_pkg::TRANSMIT_OBSERVE_OFS: b0 = {lost_packet_count_r, retry_count_r};
      radio_link_regs_pkg::CARRIER_PRESENT_OFS:  b0 = {7'h00, carrier_present_r};
      radio_link_regs_pkg::PIPE2_LOW_OFS:        b0 = pipe_low_r[2];
      radio_link_regs_pkg::PIPE3_LOW_OFS:        b0 = pipe_low_r[3];
      radio_link_regs_pkg::PIPE4_LOW_OFS:        b0 = pipe_low_r[4];
      radio_link_regs_pkg::PIPE5_LOW_OFS:        b0 = pipe_low_r[5];
      default:                                   b0 = 8'h00;
    endcase
    case (a)
      radio_link_regs_pkg::PIPE0_ADDR_OFS:    read_byte = byte_of(pipe0_receive_address_r, idx);
      radio_link_regs_pkg::PIPE1_ADDR_OFS:    read_byte = byte_of(pipe1_receive_address_r, idx);
      radio_link_regs_pkg::TRANSMIT_ADDR_OFS: read_byte = byte_of(transmit_address_r, idx);
      default:                                read_byte = (idx == 3'h0) ? b0 : 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode of the serial stream

  assign sck_rise    = ~i_csn & i_sck & ~sck_q_r;
  assign sck_fall    = ~i_csn & ~i_sck & sck_q_r;
  assign byte_done   = sck_rise && (bit_cnt_r == 3'h7);
  assign rx_byte     = {rx_sh_r, i_mosi};
  assign status_byte = {bank_indicator_r, rx_data_ready_flag_r, tx_data_sent_flag_r,
                        retry_exhausted_flag_r, pipe_num_r, tx_full_r};
  assign cur_addr    = (byte_cnt_r == 3'h0) ? rx_byte[4:0] : cmd_r[4:0];
  // Bank 1 holds a different map, so bank 0 registers only answer in bank 0
  assign wr_en       = byte_done && (byte_cnt_r != 3'h0) && !bank_indicator_r &&
                       (cmd_r[7:5] == radio_link_regs_pkg::CMD_WRITE_PREFIX);
  assign wr_idx      = byte_cnt_r - 3'h1;
  assign wr_data     = rx_byte;

  // Serial bit and byte counters, edge tracking
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_q_r    <= 1'b0;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 3'h0;
      rx_sh_r    <= 7'h00;
      cmd_r      <= 8'hFF;
    end else begin
      sck_q_r <= i_sck;
      if (i_csn) begin
        bit_cnt_r  <= 3'h0;
        byte_cnt_r <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        rx_sh_r   <= rx_byte[6:0];
        if (byte_done) begin
          if (byte_cnt_r == 3'h0) begin
            cmd_r <= rx_byte;
          end
          // Saturate so long bursts keep addressing past the top byte
          if (byte_cnt_r != 3'h7) begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
          end
        end
      end
    end
  end

  // Output shifter: status first, then read data on a fall edge
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_sh_r   <= 8'h00;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= ~i_csn;
      if (i_csn) begin
        tx_sh_r <= {status_byte[6:0], 1'b0};
        o_miso  <= status_byte[7];
      end else if (byte_done) begin
        if (cmd_r[7:5] == radio_link_regs_pkg::CMD_READ_PREFIX || byte_cnt_r == 3'h0) begin
          tx_sh_r <= (rx_byte[7:5] == radio_link_regs_pkg::CMD_READ_PREFIX ||
                      byte_cnt_r != 3'h0) && !bank_indicator_r ?
                     read_byte(cur_addr, byte_cnt_r, status_byte) : 8'h00;
        end else begin
          tx_sh_r <= 8'h00;
        end
      end else if (sck_fall) begin
        o_miso  <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable configuration

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      width_code_r       <= radio_link_regs_pkg::WIDTH_CODE_RST;
      retry_delay_code_r <= radio_link_regs_pkg::RETRY_DELAY_RST;
      retry_limit_r      <= radio_link_regs_pkg::RETRY_LIMIT_RST;
      radio_channel_r    <= radio_link_regs_pkg::RADIO_CHANNEL_RST;
      radio_setup_r      <= radio_link_regs_pkg::RADIO_SETUP_RST;
    end else if (wr_en && wr_idx == 3'h0) begin
      case (cmd_r[4:0])
        radio_link_regs_pkg::ADDR_WIDTH_SETUP_OFS: width_code_r <= wr_data[1:0];
        radio_link_regs_pkg::RETRANSMIT_SETUP_OFS: begin
          retry_delay_code_r <= wr_data[7:4];
          retry_limit_r      <= wr_data[3:0];
        end
        radio_link_regs_pkg::RADIO_CHANNEL_OFS:    radio_channel_r <= wr_data[6:0];
        radio_link_regs_pkg::RADIO_SETUP_OFS:      radio_setup_r   <= wr_data;
        default: ;
      endcase
    end
  end

  // Address storage, one byte per data byte, low byte first
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pipe0_receive_address_r <= radio_link_regs_pkg::PIPE0_ADDR_RST;
      pipe1_receive_address_r <= radio_link_regs_pkg::PIPE1_ADDR_RST;
      transmit_address_r      <= radio_link_regs_pkg::TRANSMIT_ADDR_RST;
      pipe_low_r[2]           <= radio_link_regs_pkg::PIPE2_LOW_RST;
      pipe_low_r[3]           <= radio_link_regs_pkg::PIPE3_LOW_RST;
      pipe_low_r[4]           <= radio_link_regs_pkg::PIPE4_LOW_RST;
      pipe_low_r[5]           <= radio_link_regs_pkg::PIPE5_LOW_RST;
    end else if (wr_en && wr_idx < 3'h5) begin
      case (cmd_r[4:0])
        radio_link_regs_pkg::PIPE0_ADDR_OFS:
          pipe0_receive_address_r[wr_idx*8 +: 8] <= wr_data;
        radio_link_regs_pkg::PIPE1_ADDR_OFS:
          pipe1_receive_address_r[wr_idx*8 +: 8] <= wr_data;
        radio_link_regs_pkg::TRANSMIT_ADDR_OFS:
          transmit_address_r[wr_idx*8 +: 8] <= wr_data;
        radio_link_regs_pkg::PIPE2_LOW_OFS: if (wr_idx == 3'h0) pipe_low_r[2] <= wr_data;
        radio_link_regs_pkg::PIPE3_LOW_OFS: if (wr_idx == 3'h0) pipe_low_r[3] <= wr_data;
        radio_link_regs_pkg::PIPE4_LOW_OFS: if (wr_idx == 3'h0) pipe_low_r[4] <= wr_data;
        radio_link_regs_pkg::PIPE5_LOW_OFS: if (wr_idx == 3'h0) pipe_low_r[5] <= wr_data;
        default: ;
      endcase
    end
  end

  // Bank toggle: command byte then key byte in one frame
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      bank_indicator_r <= 1'b0;
    end else if (byte_done && byte_cnt_r == 3'h1 &&
                 cmd_r == radio_link_regs_pkg::BANK_TOGGLE_COMMAND &&
                 rx_byte == radio_link_regs_pkg::BANK_TOGGLE_KEY) begin
      bank_indicator_r <= ~bank_indicator_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Retransmission control

  // A timeout with the limit used up ends the packet as lost
  assign exhaust     = i_ack_timeout && !retry_exhausted_flag_r &&
                       (retry_count_r >= retry_limit_r);
  assign retry_start = i_ack_timeout && !retry_exhausted_flag_r && !exhaust;

  // Delay timer, loaded with (code + 1) steps less one
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      delay_cnt_r     <= 17'h00000;
      delay_run_r     <= 1'b0;
      o_retransmit_go <= 1'b0;
    end else begin
      o_retransmit_go <= 1'b0;
      if (i_new_packet_start || retry_exhausted_flag_r) begin
        delay_run_r <= 1'b0;
      end else if (retry_start) begin
        delay_cnt_r <= 17'(RETRY_STEP_CYCLES * (int'(retry_delay_code_r) + 1) - 1);
        delay_run_r <= 1'b1;
      end else if (delay_run_r) begin
        if (delay_cnt_r == 17'h00000) begin
          delay_run_r     <= 1'b0;
          o_retransmit_go <= 1'b1;
        end else begin
          delay_cnt_r <= delay_cnt_r - 17'h00001;
        end
      end
    end
  end

  // Observe counters
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lost_packet_count_r <= 4'h0;
      retry_count_r       <= 4'h0;
    end else begin
      if (wr_en && wr_idx == 3'h0 && cmd_r[4:0] == radio_link_regs_pkg::RADIO_CHANNEL_OFS) begin
        lost_packet_count_r <= {3'h0, exhaust};
      end else if (exhaust && lost_packet_count_r != 4'hF) begin
        lost_packet_count_r <= lost_packet_count_r + 4'h1;
      end
      if (i_new_packet_start) begin
        retry_count_r <= 4'h0;
      end else if (retry_start) begin
        retry_count_r <= retry_count_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags, a set in the clearing cycle wins

  assign rx_clr = wr_en && wr_idx == 3'h0 &&
                  cmd_r[4:0] == radio_link_regs_pkg::EVENT_STATUS_OFS &&
                  wr_data[radio_link_regs_pkg::STAT_RX_BIT];
  assign tx_clr = wr_en && wr_idx == 3'h0 &&
                  cmd_r[4:0] == radio_link_regs_pkg::EVENT_STATUS_OFS &&
                  wr_data[radio_link_regs_pkg::STAT_TX_BIT];
  assign rt_clr = wr_en && wr_idx == 3'h0 &&
                  cmd_r[4:0] == radio_link_regs_pkg::EVENT_STATUS_OFS &&
                  wr_data[radio_link_regs_pkg::STAT_RETRY_BIT];
  assign tx_sent_evt = i_auto_ack_active ? i_ack_received : i_tx_done;
  assign rx_nxt = i_rx_payload_arrived | (rx_data_ready_flag_r & ~rx_clr);
  assign tx_nxt = tx_sent_evt | (tx_data_sent_flag_r & ~tx_clr);
  assign rt_nxt = exhaust | (retry_exhausted_flag_r & ~rt_clr);

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_data_ready_flag_r   <= 1'b0;
      tx_data_sent_flag_r    <= 1'b0;
      retry_exhausted_flag_r <= 1'b0;
      o_comm_blocked         <= 1'b0;
      o_irq_n                <= 1'b1;
    end else begin
      rx_data_ready_flag_r   <= rx_nxt;
      tx_data_sent_flag_r    <= tx_nxt;
      retry_exhausted_flag_r <= rt_nxt;
      o_comm_blocked         <= rt_nxt;
      o_irq_n <= ~((rx_nxt & ~i_rx_ready_irq_mask) | (tx_nxt & ~i_tx_sent_irq_mask) |
                   (rt_nxt & ~i_retry_limit_irq_mask));
    end
  end

  // Sampled read-only state
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pipe_num_r        <= radio_link_regs_pkg::PIPE_NUM_EMPTY;
      tx_full_r         <= 1'b0;
      carrier_present_r <= 1'b0;
    end else begin
      pipe_num_r        <= i_rx_pipe_num;
      tx_full_r         <= i_tx_fifo_full;
      carrier_present_r <= i_carrier_present;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered settings to the radio engine

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_width_code         <= radio_link_regs_pkg::WIDTH_CODE_RST;
      o_radio_channel      <= radio_link_regs_pkg::RADIO_CHANNEL_RST;
      o_air_rate_select    <= radio_link_regs_pkg::RADIO_SETUP_RST[3];
      o_output_power_level <= radio_link_regs_pkg::RADIO_SETUP_RST[2:1];
      o_rx_gain_high       <= radio_link_regs_pkg::RADIO_SETUP_RST[0];
      o_bank_indicator     <= 1'b0;
      o_pipe0_addr         <= 40'h0000000000;
      o_pipe1_addr         <= 40'h0000000000;
      o_pipe2_addr         <= 40'h0000000000;
      o_pipe3_addr         <= 40'h0000000000;
      o_pipe4_addr         <= 40'h0000000000;
      o_pipe5_addr         <= 40'h0000000000;
      o_tx_addr            <= 40'h0000000000;
    end else begin
      o_width_code         <= width_code_r;
      o_radio_channel      <= radio_channel_r;
      o_air_rate_select    <= radio_setup_r[3];
      o_output_power_level <= radio_setup_r[2:1];
      o_rx_gain_high       <= radio_setup_r[0];
      o_bank_indicator     <= bank_indicator_r;
      o_pipe0_addr <= mask_addr(pipe0_receive_address_r, width_code_r);
      o_pipe1_addr <= mask_addr(pipe1_receive_address_r, width_code_r);
      o_pipe2_addr <= mask_addr({pipe1_receive_address_r[39:8], pipe_low_r[2]},
                                width_code_r);
      o_pipe3_addr <= mask_addr({pipe1_receive_address_r[39:8], pipe_low_r[3]},
                                width_code_r);
      o_pipe4_addr <= mask_addr({pipe1_receive_address_r[39:8], pipe_low_r[4]},
                                width_code_r);
      o_pipe5_addr <= mask_addr({pipe1_receive_address_r[39:8], pipe_low_r[5]},
                                width_code_r);
      o_tx_addr    <= mask_addr(transmit_address_r, width_code_r);
    end
  end

endmodule

// ==== tb/spi_host.sv ====
`timescale 1ns/100ps
// Host side of the serial port, mode 0, sck high 3 clocks and low 4 clocks per bit
module spi_host (
  input  wire logic i_clk_sys,
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_csn,
  output logic      o_mosi
);
  initial begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_mosi = 1'b0;
  end
  // One frame: byte k sits at d[8k+7:8k], each byte MSB bit first
  task automatic xfer(input logic [47:0] d, input int n, output logic [47:0] q);
    q = '0;
    @(posedge i_clk_sys) o_csn <= 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      @(posedge i_clk_sys) o_mosi <= d[8 * (i / 8) + 7 - i % 8];
      repeat (3) @(posedge i_clk_sys);
      q[8 * (i / 8) + 7 - i % 8] = i_miso;
      o_sck <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      o_sck <= 1'b0;
    end
    @(posedge i_clk_sys) o_csn <= 1'b1;
    // Released line must not keep the last bit
    o_mosi <= ~o_mosi;
    repeat (2) @(posedge i_clk_sys);
  endtask
endmodule

// ==== tb/regs_assertions.sv ====
`timescale 1ns/100ps
module regs_checker (
  input wire logic        i_clk_sys, i_rstn, i_csn, i_auto_ack_active,
  input wire logic        i_rx_payload_arrived, i_tx_done, i_ack_received,
  input wire logic        i_rx_ready_irq_mask, i_tx_sent_irq_mask, i_retry_limit_irq_mask,
  input wire logic        o_irq_n, o_comm_blocked, o_miso_oe,
  input wire logic [1:0]  o_width_code,
  input wire logic [39:0] o_pipe1_addr, o_pipe2_addr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////
  // Unmasked events pull the pin low one cycle on
  rx_irq_low_a: assert property (i_rx_payload_arrived && !i_rx_ready_irq_mask
    |=> !o_irq_n) else $error("rx event left irq high");
  sent_irq_low_a: assert property (i_tx_done && !i_auto_ack_active && !i_tx_sent_irq_mask
    |=> !o_irq_n) else $error("sent event left irq high");
  ack_irq_low_a: assert property (i_ack_received && i_auto_ack_active
    && !i_tx_sent_irq_mask |=> !o_irq_n) else $error("ack event left irq high");
  limit_irq_low_a: assert property (o_comm_blocked && !i_retry_limit_irq_mask
    |-> !o_irq_n) else $error("blocked without irq");
  // No write can happen while deselected, so blocking holds
  block_hold_a: assert property (o_comm_blocked && i_csn |=> o_comm_blocked)
    else $error("block dropped without host write");
  miso_drive_a: assert property (!i_csn |=> o_miso_oe)
    else $error("status not driven in frame");
  pipe_upper_a: assert property (o_pipe2_addr[39:8] == o_pipe1_addr[39:8])
    else $error("pipe 2 upper bytes differ");
  width_mask_a: assert property (o_width_code == 2'h1 && $stable(o_width_code)
    |-> o_pipe1_addr[39:24] == 16'h0) else $error("upper bytes not masked");
endmodule
bind radio_link_config_status_regs regs_checker u_chk (.*);

// ==== tb/radio_link_config_status_regs_bench.sv ====
`timescale 1ns/100ps
module radio_link_config_status_regs_bench;
  logic        i_clk_sys, i_rstn, sck, csn, mosi, miso, irq_n, blocked, go, bank;
  logic        rx_arr, tx_done, ack_rx, auto_ack, ack_to, new_pkt, tx_full;
  logic [2:0]  pipe_num;
  logic [1:0]  width;
  logic [6:0]  chan;
  logic [39:0] p0, p1, p2, ta;
  wire  [3:0]  rs;
  logic [47:0] q;
  int          error_cnt, cmp_count, cyc, n;
  radio_link_config_status_regs #(.RETRY_STEP_CYCLES(5)) u_dut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_sck(sck), .i_csn(csn), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(), .o_irq_n(irq_n), .i_rx_payload_arrived(rx_arr),
    .i_rx_pipe_num(pipe_num), .i_tx_done(tx_done), .i_ack_received(ack_rx),
    .i_auto_ack_active(auto_ack), .i_ack_timeout(ack_to), .i_new_packet_start(new_pkt),
    .i_tx_fifo_full(tx_full), .i_carrier_present(1'b0), .i_rx_ready_irq_mask(1'b0),
    .i_tx_sent_irq_mask(1'b0), .i_retry_limit_irq_mask(1'b0), .o_width_code(width),
    .o_radio_channel(chan), .o_air_rate_select(rs[3]), .o_output_power_level(rs[2:1]),
    .o_rx_gain_high(rs[0]), .o_bank_indicator(bank), .o_comm_blocked(blocked),
    .o_retransmit_go(go), .o_pipe0_addr(p0), .o_pipe1_addr(p1), .o_pipe2_addr(p2),
    .o_pipe3_addr(), .o_pipe4_addr(), .o_pipe5_addr(), .o_tx_addr(ta));
  spi_host u_host (.i_clk_sys(i_clk_sys), .i_miso(miso), .o_sck(sck), .o_csn(csn),
    .o_mosi(mosi));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [39:0] g, input logic [39:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task rd(input logic [4:0] a, input int k);
    u_host.xfer({40'h0, radio_link_regs_pkg::CMD_READ_PREFIX, a}, k + 1, q);
  endtask
  task wr(input logic [4:0] a, input logic [39:0] d, input int k);
    u_host.xfer({d, radio_link_regs_pkg::CMD_WRITE_PREFIX, a}, k + 1, q);
  endtask
  task ev(input logic [6:0] v);
    @(posedge i_clk_sys) {rx_arr, tx_done, ack_rx, auto_ack, ack_to, new_pkt, tx_full} <= v;
    @(posedge i_clk_sys) {rx_arr, tx_done, ack_rx, ack_to, new_pkt} <= 5'h00;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [39:0] e;
    for (int a = 3; a < 18; a++) begin
      case (a)
        3, 4: e = 40'h03;
        5: e = 40'h02;
        6: e = 40'h3F;
        7: e = 40'h0E;
        10, 16: e = 40'hE7E7E7E7E7;
        11: e = 40'hC2C2C2C2C2;
        12, 13, 14, 15: e = 40'hC3 + a - 12;
        default: e = 40'h00;
      endcase
      rd(a[4:0], (e > 40'hFF) ? 5 : 1);
      chk(q[47:8], e);
    end
    chk(rs, 40'hF);
    $display("reset values done");
  endtask
  task t_addr;
    wr(5'h03, 40'h01, 1);
    wr(5'h0B, 40'h332211, 3);
    chk(width, 40'h01);
    chk(p1, 40'h332211);
    chk(p2, 40'h3322C3);
    wr(5'h03, 40'h03, 1);
    chk(p1, 40'hC2C2332211);
    wr(5'h10, 40'h0102030405, 5);
    wr(5'h0A, 40'h0102030405, 5);
    chk(ta, 40'h0102030405);
    chk(p0, 40'h0102030405);
    $display("address width done");
  endtask
  task t_events;
    pipe_num <= 3'h2;
    ev(7'h41);
    rd(5'h07, 1);
    chk(q[15:0], 40'h4545);
    pipe_num <= 3'h7;
    wr(5'h07, 40'h60, 1);
    ev(7'h28);
    rd(5'h07, 0);
    chk(q[7:0], 40'h0E);
    ev(7'h18);
    rd(5'h07, 0);
    chk(q[7:0], 40'h2E);
    wr(5'h07, 40'h20, 1);
    ev(7'h20);
    rd(5'h07, 0);
    chk(q[7:0], 40'h2E);
    chk(irq_n, 40'h0);
    wr(5'h07, 40'h20, 1);
    chk(irq_n, 40'h1);
    $display("event flags done");
  endtask
  task t_retry;
    wr(5'h04, 40'h01, 1);
    ev(7'h04);
    for (n = 0; n < 20 && go !== 1'b1; n++) @(posedge i_clk_sys);
    chk(n > 3 && n < 9, 40'h1);
    rd(5'h08, 1);
    chk(q[15:8], 40'h01);
    ev(7'h04);
    rd(5'h08, 1);
    chk(q[15:0], 40'h111E);
    wr(5'h05, 40'h45, 1);
    ev(7'h02);
    rd(5'h08, 1);
    chk(q[15:8], 40'h00);
    chk(chan, 40'h45);
    wr(5'h07, 40'h10, 1);
    chk(blocked, 40'h0);
    $display("retry done");
  endtask
  task t_bank;
    u_host.xfer(48'h5350, 2, q);
    rd(5'h05, 1);
    chk(q[15:0], 40'h008E);
    chk(bank, 40'h1);
    u_host.xfer(48'h5350, 2, q);
    chk(bank, 40'h0);
    $display("bank toggle done");
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Runaway guard, the full run needs well under 10000 cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    {rx_arr, tx_done, ack_rx, auto_ack, ack_to, new_pkt, tx_full} = 7'h00;
    pipe_num = 3'h7;
    i_rstn = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    t_reset;
    t_addr;
    t_events;
    t_retry;
    t_bank;
    stop_test;
  end
endmodule
